//--- rtl/ppg_defs.svh
`ifndef PPG_DEFS_SVH
`define PPG_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PPG_OFS_STATUS      8'h00
`define PPG_OFS_IRQ_MASK    8'h01
`define PPG_OFS_PIN_CFG     8'h02
`define PPG_OFS_FIFO_THR    8'h06
`define PPG_OFS_PART_ID     8'h08
`define PPG_OFS_CLK_RATIO   8'h0a
`define PPG_OFS_OP_MODE     8'h10
`define PPG_OFS_SAMPLE_CTL  8'h11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPG_RST_IRQ_MASK    16'h00ff
`define PPG_RST_PIN_CFG     16'h0000
`define PPG_RST_FIFO_THR    16'h0000
`define PPG_RST_OP_MODE     16'h0000
`define PPG_RST_SAMPLE_CTL  16'h5000
`define PPG_ZERO16          16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPG_BIT_FIFO_MASK   8
`define PPG_BIT_SECOND      6
`define PPG_BIT_FIRST       5
`define PPG_BIT_PIN_ON      2
`define PPG_BIT_PIN_DRIVE   1
`define PPG_BIT_PIN_LEVEL   0
`define PPG_THR_HI          13
`define PPG_THR_LO          8
`define PPG_MODE_HI         1
`define PPG_MODE_LO         0
`define PPG_BIT_READBACK    13
`define PPG_BIT_FULL_HOLD   12
`define PPG_RATIO_HI        11
`define PPG_CNT_HI          15
`define PPG_CNT_LO          8

// ----------------------------------------------------------------
// counts and identity
// ----------------------------------------------------------------
`define PPG_RATIO_ZERO      12'h000
`define PPG_RATIO_ONE       12'h001
`define PPG_RATIO_MAX       12'hfff
// arbitrary value, not tied to any real part
`define PPG_PART_ID         16'h5a3c

`endif

//--- rtl/ppg_pkg.sv
package ppg_pkg;

	typedef enum logic [1:0] {
		PPG_MODE_STANDBY = 2'h0,
		PPG_MODE_PROGRAM = 2'h1,
		PPG_MODE_SAMPLE  = 2'h2
	} ppg_mode_e;

	typedef enum logic [1:0] {
		PPG_CAL_IDLE = 2'h0,
		PPG_CAL_SYNC = 2'h1,
		PPG_CAL_HALF = 2'h3,
		PPG_CAL_FULL = 2'h2
	} ppg_cal_e;

	typedef logic [11:0] ppg_ratio_t;

endpackage

//--- rtl/ppg_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none

interface ppg_ctl_if;
	logic               pin_on;
	logic               pin_drive_style;
	logic               pin_level_sel;
	logic               pending;
	logic               measure_on;
	logic               slow_clk;
	ppg_pkg::ppg_ratio_t ratio;

	modport regs_irq (output pin_on, output pin_drive_style, output pin_level_sel,
		output pending);
	modport pin (input pin_on, input pin_drive_style, input pin_level_sel,
		input pending);
	modport regs_cal (output measure_on, output slow_clk, input ratio);
	modport cal (input measure_on, input slow_clk, output ratio);
endinterface

`default_nettype wire

//--- rtl/ppg_irq_pin.sv
`timescale 1ns/100ps
`default_nettype none

module ppg_irq_pin (
	input  wire logic i_clk,        // system clock
	input  wire logic i_rst,        // sync reset, active high
	ppg_ctl_if.pin    ctl,          // pin configuration and pending
	output var  logic o_pin_o,      // pin output level
	output var  logic o_pin_oe      // pin output enable, high drives
);
	wire level_next;
	wire oe_next;

	assign level_next = ctl.pending ^ ctl.pin_level_sel;
	assign oe_next    = ctl.pin_on & (~ctl.pin_drive_style | ctl.pending);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pin_o  <= 1'b0;
			o_pin_oe <= 1'b0;
		end else begin
			o_pin_o  <= level_next;
			o_pin_oe <= oe_next;
		end
	end

	chk_pin_floats_off: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!ctl.pin_on |=> !o_pin_oe) else $error("irq pin driven while disabled");
	chk_open_drain_idle: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ctl.pin_on && ctl.pin_drive_style && !ctl.pending |=> !o_pin_oe)
		else $error("open drain pin driven while idle");
	chk_pin_polarity: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ctl.pin_on && ctl.pending |=> o_pin_oe && (o_pin_o == !$past(ctl.pin_level_sel)))
		else $error("irq pin level wrong");
endmodule

`default_nettype wire

//--- rtl/ppg_clk_ratio.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppg_defs.svh"

module ppg_clk_ratio (
	input  wire logic i_clk,        // fast clock being measured
	input  wire logic i_rst,        // sync reset, active high
	ppg_ctl_if.cal    ctl           // enable, slow clock level, result
);
	ppg_pkg::ppg_cal_e   state_reg;
	ppg_pkg::ppg_cal_e   state_next;
	ppg_pkg::ppg_ratio_t cnt_reg;
	ppg_pkg::ppg_ratio_t ratio_reg;
	logic                slow_prev_reg;

	wire slow_rise;
	wire cnt_sat;

	assign slow_rise = ctl.slow_clk & ~slow_prev_reg;
	assign cnt_sat   = (cnt_reg == `PPG_RATIO_MAX);
	assign ctl.ratio = ratio_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ppg_pkg::PPG_CAL_IDLE: state_next = ppg_pkg::PPG_CAL_SYNC;
			ppg_pkg::PPG_CAL_SYNC: if (slow_rise) state_next = ppg_pkg::PPG_CAL_HALF;
			ppg_pkg::PPG_CAL_HALF: if (slow_rise) state_next = ppg_pkg::PPG_CAL_FULL;
			ppg_pkg::PPG_CAL_FULL: if (slow_rise) state_next = ppg_pkg::PPG_CAL_HALF;
			default:               state_next = ppg_pkg::PPG_CAL_IDLE;
		endcase
		if (!ctl.measure_on) state_next = ppg_pkg::PPG_CAL_IDLE;
	end

	// counts fast edges across two slow periods, rising edge to rising edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg     <= ppg_pkg::PPG_CAL_IDLE;
			cnt_reg       <= `PPG_RATIO_ZERO;
			ratio_reg     <= `PPG_RATIO_ZERO;
			slow_prev_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			slow_prev_reg <= ctl.slow_clk;
			if (state_reg == ppg_pkg::PPG_CAL_FULL && slow_rise && ctl.measure_on)
				ratio_reg <= cnt_reg + `PPG_RATIO_ONE;
			if (slow_rise && state_reg != ppg_pkg::PPG_CAL_HALF)
				cnt_reg <= `PPG_RATIO_ZERO;
			else if (!cnt_sat)
				cnt_reg <= cnt_reg + `PPG_RATIO_ONE;
		end
	end

	chk_ratio_capture: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ctl.measure_on && state_reg == ppg_pkg::PPG_CAL_FULL && slow_rise
		|=> ctl.ratio == $past(cnt_reg) + `PPG_RATIO_ONE) else $error("ratio not captured");
endmodule

`default_nettype wire

//--- rtl/ppg_system_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppg_defs.svh"

// How it works
// - fifo mask bit 0 lets the fifo threshold condition raise the interrupt
// - second window mask resets to 1; writing 0 enables its sample interrupt
// - first window mask resets to 1; writing 0 enables its sample interrupt
// - pin enable 0 floats the pin; status flags keep recording events
// - drive style 0 always drives; 1 drives only while asserted
// - polarity 0 is active high, 1 is active low
// - fifo interrupt when word count strictly exceeds 6-bit threshold
// - fifo interrupt drops by itself once count no longer exceeds threshold
// - with measure on, count fast cycles over two slow periods into 12 bits
// - mode field: 0 standby, 1 program, 2 sample
// - readback bit: 0 block sum, 1 block average of extended data
// - full hold 0 wraps and overwrites; 1 writes only when not full
// - fifo fill is in bytes, threshold in words; halve bytes to compare
// - window flags set on events, write 1 clears, write 0 ignored
module ppg_system_control_regs (
	input  wire logic       i_clk,                  // system clock, 125 MHz
	input  wire logic       i_rst,                  // sync reset, active high
	input  wire logic [7:0] i_reg_addr,             // register offset
	input  wire logic [15:0] i_reg_wdata,           // register write data
	input  wire logic       i_reg_wr,               // write strobe
	input  wire logic       i_reg_rd,               // read strobe
	output var  logic [15:0] o_reg_rdata,           // read data
	output var  logic       o_reg_rvalid,           // read data valid pulse
	input  wire logic       i_first_window_done,    // first window sample pulse
	input  wire logic       i_second_window_done,   // second window sample pulse
	input  wire logic [7:0] i_fifo_byte_count,      // bytes held in the fifo
	input  wire logic       i_slow_clk,             // slow clock level
	input  wire logic       i_fast_osc_measure_on,  // clock ratio measurement enable
	output var  logic       o_irq_pin_o,            // interrupt pin level
	output var  logic       o_irq_pin_oe,           // interrupt pin enable, high drives
	output var  logic       o_irq_pending,          // any unmasked source pending
	output var  logic [1:0] o_operating_mode,       // operating mode
	output var  logic       o_extended_readback_sel,// 0 sum, 1 average
	output var  logic       o_queue_full_hold,      // 1 holds new data when full
	output var  logic       o_first_window_flag,    // first window status flag
	output var  logic       o_second_window_flag    // second window status flag
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [15:0] irq_mask_reg;
	logic [15:0] pin_cfg_reg;
	logic [15:0] fifo_thr_reg;
	logic [15:0] op_mode_reg;
	logic [15:0] sample_ctl_reg;
	logic        first_flag_reg;
	logic        second_flag_reg;
	logic        first_flag_next;
	logic        second_flag_next;
	logic        pending_reg;
	logic [15:0] rdata_next;

	ppg_ctl_if ctl ();

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire hit_status;
	wire hit_mask;
	wire hit_pin;
	wire hit_thr;
	wire hit_id;
	wire hit_ratio;
	wire hit_mode;
	wire hit_sample;

	assign hit_status = (i_reg_addr == `PPG_OFS_STATUS);
	assign hit_mask   = (i_reg_addr == `PPG_OFS_IRQ_MASK);
	assign hit_pin    = (i_reg_addr == `PPG_OFS_PIN_CFG);
	assign hit_thr    = (i_reg_addr == `PPG_OFS_FIFO_THR);
	assign hit_id     = (i_reg_addr == `PPG_OFS_PART_ID);
	assign hit_ratio  = (i_reg_addr == `PPG_OFS_CLK_RATIO);
	assign hit_mode   = (i_reg_addr == `PPG_OFS_OP_MODE);
	assign hit_sample = (i_reg_addr == `PPG_OFS_SAMPLE_CTL);

	wire wr_status;
	wire clr_first;
	wire clr_second;

	assign wr_status  = i_reg_wr & hit_status;
	assign clr_first  = wr_status & i_reg_wdata[`PPG_BIT_FIRST];
	assign clr_second = wr_status & i_reg_wdata[`PPG_BIT_SECOND];

	// ----------------------------------------------------------------
	// fifo level compare
	// ----------------------------------------------------------------
	wire [6:0] fifo_words;
	wire [5:0] queue_level_limit;
	wire       fifo_over;

	assign fifo_words        = i_fifo_byte_count[7:1];
	assign queue_level_limit = fifo_thr_reg[`PPG_THR_HI:`PPG_THR_LO];
	assign fifo_over         = fifo_words > {1'b0, queue_level_limit};

	// ----------------------------------------------------------------
	// interrupt sources
	// ----------------------------------------------------------------
	wire first_window_irq_block;
	wire second_window_irq_block;
	wire fifo_irq_block;
	wire pending_next;

	assign first_window_irq_block  = irq_mask_reg[`PPG_BIT_FIRST];
	assign second_window_irq_block = irq_mask_reg[`PPG_BIT_SECOND];
	assign fifo_irq_block          = irq_mask_reg[`PPG_BIT_FIFO_MASK];
	assign pending_next = (first_flag_next & ~first_window_irq_block)
		| (second_flag_next & ~second_window_irq_block)
		| (fifo_over & ~fifo_irq_block);

	// set wins over a simultaneous write-1 clear
	always_comb begin
		first_flag_next  = (first_flag_reg & ~clr_first) | i_first_window_done;
		second_flag_next = (second_flag_reg & ~clr_second) | i_second_window_done;
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = `PPG_ZERO16;
		if (hit_status) begin
			rdata_next[`PPG_CNT_HI:`PPG_CNT_LO] = i_fifo_byte_count;
			rdata_next[`PPG_BIT_SECOND]         = second_flag_reg;
			rdata_next[`PPG_BIT_FIRST]          = first_flag_reg;
		end else if (hit_mask) begin
			rdata_next = irq_mask_reg;
		end else if (hit_pin) begin
			rdata_next = pin_cfg_reg;
		end else if (hit_thr) begin
			rdata_next = fifo_thr_reg;
		end else if (hit_id) begin
			rdata_next = `PPG_PART_ID;
		end else if (hit_ratio) begin
			rdata_next[`PPG_RATIO_HI:0] = ctl.ratio;
		end else if (hit_mode) begin
			rdata_next = op_mode_reg;
		end else if (hit_sample) begin
			rdata_next = sample_ctl_reg;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_mask_reg   <= `PPG_RST_IRQ_MASK;
			pin_cfg_reg    <= `PPG_RST_PIN_CFG;
			fifo_thr_reg   <= `PPG_RST_FIFO_THR;
			op_mode_reg    <= `PPG_RST_OP_MODE;
			sample_ctl_reg <= `PPG_RST_SAMPLE_CTL;
		end else if (i_reg_wr) begin
			if (hit_mask)   irq_mask_reg   <= i_reg_wdata;
			if (hit_pin)    pin_cfg_reg    <= i_reg_wdata;
			if (hit_thr)    fifo_thr_reg   <= i_reg_wdata;
			if (hit_mode)   op_mode_reg    <= i_reg_wdata;
			if (hit_sample) sample_ctl_reg <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			first_flag_reg  <= 1'b0;
			second_flag_reg <= 1'b0;
			pending_reg     <= 1'b0;
		end else begin
			first_flag_reg  <= first_flag_next;
			second_flag_reg <= second_flag_next;
			pending_reg     <= pending_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_reg_rdata  <= `PPG_ZERO16;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) o_reg_rdata <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs and submodules
	// ----------------------------------------------------------------
	assign o_operating_mode        = op_mode_reg[`PPG_MODE_HI:`PPG_MODE_LO];
	assign o_extended_readback_sel = sample_ctl_reg[`PPG_BIT_READBACK];
	assign o_queue_full_hold       = sample_ctl_reg[`PPG_BIT_FULL_HOLD];
	assign o_first_window_flag     = first_flag_reg;
	assign o_second_window_flag    = second_flag_reg;
	assign o_irq_pending           = pending_reg;

	assign ctl.pin_on          = pin_cfg_reg[`PPG_BIT_PIN_ON];
	assign ctl.pin_drive_style = pin_cfg_reg[`PPG_BIT_PIN_DRIVE];
	assign ctl.pin_level_sel   = pin_cfg_reg[`PPG_BIT_PIN_LEVEL];
	assign ctl.pending         = pending_reg;
	assign ctl.measure_on      = i_fast_osc_measure_on;
	assign ctl.slow_clk        = i_slow_clk;

	ppg_irq_pin u_irq_pin (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.ctl      (ctl.pin),
		.o_pin_o  (o_irq_pin_o),
		.o_pin_oe (o_irq_pin_oe)
	);

	ppg_clk_ratio u_clk_ratio (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.ctl   (ctl.cal)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_fifo_irq_on: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!fifo_irq_block && fifo_over |=> o_irq_pending) else $error("fifo irq missing");
	chk_fifo_irq_drop: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!fifo_over && !first_flag_next && !second_flag_next |=> !o_irq_pending)
		else $error("irq held without source");
	chk_fifo_compare: assert property (
		@(posedge i_clk) disable iff (i_rst)
		fifo_over == (i_fifo_byte_count >
			{1'b0, fifo_thr_reg[`PPG_THR_HI:`PPG_THR_LO], 1'b1}))
		else $error("fifo compare wrong");
	chk_second_irq: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_second_window_done && !second_window_irq_block |=> o_irq_pending && o_second_window_flag)
		else $error("second window irq missing");
	chk_first_irq: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_first_window_done && !first_window_irq_block |=> o_irq_pending && o_first_window_flag)
		else $error("first window irq missing");
	chk_flag_set_wins: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_first_window_done && clr_first |=> o_first_window_flag)
		else $error("flag set lost to clear");
	chk_flag_w1c: assert property (
		@(posedge i_clk) disable iff (i_rst)
		clr_second && !i_second_window_done |=> !o_second_window_flag)
		else $error("write one did not clear");
	chk_flag_w0_keep: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_first_window_flag && !clr_first |=> o_first_window_flag)
		else $error("flag lost without clear");
	chk_masked_silent: assert property (
		@(posedge i_clk) disable iff (i_rst)
		irq_mask_reg[`PPG_BIT_FIFO_MASK] && irq_mask_reg[`PPG_BIT_SECOND]
			&& irq_mask_reg[`PPG_BIT_FIRST] |=> !o_irq_pending)
		else $error("irq while all masked");
	chk_mode_write: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_reg_wr && hit_mode |=> o_operating_mode == $past(i_reg_wdata[`PPG_MODE_HI:`PPG_MODE_LO]))
		else $error("mode not written");
	chk_read_latency: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_reg_rd && hit_ratio
		|=> o_reg_rvalid && o_reg_rdata[`PPG_CNT_HI:`PPG_RATIO_HI+1] == 4'h0)
		else $error("ratio read wrong");
endmodule

`default_nettype wire

//--- testbench/ppg_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ppg_host_model (
	input  wire logic i_pin_o,    // device pin level
	input  wire logic i_pin_oe,   // device pin enable, high drives
	input  wire logic i_pull_up,  // board pull: 1 up, 0 down
	output wire logic o_line,     // resolved line level
	output wire logic o_asserted  // host sees an interrupt
);
	// a released line settles at the board pull, sized to the idle level
	assign o_line     = i_pin_oe ? i_pin_o : i_pull_up;
	assign o_asserted = (o_line !== i_pull_up);
endmodule

`default_nettype wire

//--- testbench/test_ppg_system_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppg_defs.svh"

module test_ppg_system_control_regs;
	localparam int SLOW_HALF = 20;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        first_done = 1'b0;
	logic        second_done = 1'b0;
	logic [7:0]  byte_count = 8'h00;
	logic        slow_clk = 1'b0;
	logic        measure_on = 1'b0;
	logic        pull_up = 1'b0;
	logic [15:0] rdata;
	logic        rvalid, pin_o, pin_oe, pending, readback_sel, full_hold;
	logic        first_flag, second_flag, line, line_asserted;
	logic [1:0]  op_mode;
	int          fails = 0;
	int          n_checks = 0;

	always #4 i_clk = ~i_clk;

	// slow clock runs free, synchronous to the system clock
	always begin
		repeat (SLOW_HALF) @(posedge i_clk);
		#1 slow_clk = ~slow_clk;
	end

	ppg_system_control_regs u_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_first_window_done(first_done), .i_second_window_done(second_done),
		.i_fifo_byte_count(byte_count), .i_slow_clk(slow_clk),
		.i_fast_osc_measure_on(measure_on), .o_irq_pin_o(pin_o), .o_irq_pin_oe(pin_oe),
		.o_irq_pending(pending), .o_operating_mode(op_mode),
		.o_extended_readback_sel(readback_sel), .o_queue_full_hold(full_hold),
		.o_first_window_flag(first_flag), .o_second_window_flag(second_flag));

	ppg_host_model u_host (.i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_pull_up(pull_up),
		.o_line(line), .o_asserted(line_asserted));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge i_clk);
		#1;
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge i_clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge i_clk);
		#1;
		rd = 1'b0;
		addr = ~a;
		chk(rvalid, 1'b1, "read valid");
		chk(rdata, exp, what);
	endtask

	task automatic pulse(input int w);
		@(posedge i_clk);
		#1;
		first_done = (w == 0);
		second_done = (w == 1);
		@(posedge i_clk);
		#1;
		first_done = 1'b0;
		second_done = 1'b0;
	endtask

	task automatic set_bytes(input logic [7:0] b);
		@(posedge i_clk);
		#1;
		byte_count = b;
		@(posedge i_clk);
		#1;
	endtask

	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_chk(`PPG_OFS_IRQ_MASK, 16'h00ff, "mask reset");
		rd_chk(`PPG_OFS_PIN_CFG, 16'h0000, "pin config reset");
		rd_chk(`PPG_OFS_SAMPLE_CTL, 16'h5000, "sample control reset");
		chk(full_hold, 1'b1, "full hold at reset");
		chk(pin_oe, 1'b0, "pin floats at reset");
		wr_reg(`PPG_OFS_PART_ID, 16'h0000);
		rd_chk(`PPG_OFS_PART_ID, `PPG_PART_ID, "identifier read only");
		wr_reg(`PPG_OFS_CLK_RATIO, 16'h0fff);
		rd_chk(`PPG_OFS_CLK_RATIO, 16'h0000, "ratio read only");
		rd_chk(8'h03, 16'h0000, "unmapped read");
		$display("t_reset done");
	endtask

	task automatic t_modes();
		logic [15:0] v;
		for (int m = 0; m < 3; m++) begin
			v = {14'h0000, 2'(m)};
			wr_reg(`PPG_OFS_OP_MODE, v);
			chk(op_mode, v, "mode output");
			rd_chk(`PPG_OFS_OP_MODE, v, "mode readback");
		end
		for (int s = 0; s < 4; s++) begin
			v = {2'b01, 2'(s), 12'h000};
			wr_reg(`PPG_OFS_SAMPLE_CTL, v);
			chk(readback_sel, v[13], "readback select");
			chk(full_hold, v[12], "full hold");
		end
		$display("t_modes done");
	endtask

	task automatic t_windows();
		logic [15:0] b;
		for (int w = 0; w < 2; w++) begin
			b = (w == 0) ? 16'h0020 : 16'h0040;
			wr_reg(`PPG_OFS_IRQ_MASK, 16'h00ff);
			pulse(w);
			chk(pending, 1'b0, "masked window silent");
			rd_chk(`PPG_OFS_STATUS, b, "flag set while masked");
			wr_reg(`PPG_OFS_STATUS, 16'h0000);
			rd_chk(`PPG_OFS_STATUS, b, "write zero keeps flag");
			wr_reg(`PPG_OFS_STATUS, b);
			rd_chk(`PPG_OFS_STATUS, 16'h0000, "write one clears");
			wr_reg(`PPG_OFS_IRQ_MASK, 16'h00ff & ~b);
			pulse(w);
			chk(pending, 1'b1, "unmasked window raises");
			chk(w ? second_flag : first_flag, 1'b1, "flag output");
			wr_reg(`PPG_OFS_STATUS, b);
			@(posedge i_clk);
			#1;
			chk(pending, 1'b0, "cleared flag drops");
			@(posedge i_clk);
			#1;
			addr = `PPG_OFS_STATUS;
			wdata = b;
			wr = 1'b1;
			first_done = (w == 0);
			second_done = (w == 1);
			@(posedge i_clk);
			#1;
			wr = 1'b0;
			addr = 8'hff;
			first_done = 1'b0;
			second_done = 1'b0;
			chk(w ? second_flag : first_flag, 1'b1, "set wins over clear");
			chk(pending, 1'b1, "set wins keeps irq");
			wr_reg(`PPG_OFS_STATUS, b);
		end
		wr_reg(`PPG_OFS_IRQ_MASK, 16'h00ff);
		$display("t_windows done");
	endtask

	task automatic t_fifo();
		wr_reg(`PPG_OFS_FIFO_THR, 16'h0300);
		set_bytes(8'h07);
		chk(pending, 1'b0, "three words not above three");
		set_bytes(8'h08);
		chk(pending, 1'b1, "four words above three");
		rd_chk(`PPG_OFS_STATUS, 16'h0800, "byte count in status");
		set_bytes(8'h06);
		chk(pending, 1'b0, "drops without clear");
		wr_reg(`PPG_OFS_IRQ_MASK, 16'h01ff);
		set_bytes(8'h7e);
		chk(pending, 1'b0, "masked fifo silent");
		wr_reg(`PPG_OFS_IRQ_MASK, 16'h00ff);
		wr_reg(`PPG_OFS_FIFO_THR, 16'hff00);
		@(posedge i_clk);
		#1;
		chk(pending, 1'b0, "63 words not above 63");
		set_bytes(8'hff);
		chk(pending, 1'b1, "127 words above 63");
		set_bytes(8'h00);
		wr_reg(`PPG_OFS_FIFO_THR, 16'h0000);
		$display("t_fifo done");
	endtask

	task automatic t_pin();
		logic [3:0] cv;
		logic       exp_oe;
		for (int c = 0; c < 16; c++) begin
			cv = 4'(c);
			pull_up = cv[0];
			wr_reg(`PPG_OFS_PIN_CFG, {13'h0000, cv[2:0]});
			set_bytes(cv[3] ? 8'h02 : 8'h00);
			@(posedge i_clk);
			#1;
			exp_oe = cv[2] & (~cv[1] | cv[3]);
			chk(pin_oe, exp_oe, "pin enable");
			chk(pin_o, cv[3] ^ cv[0], "pin level");
			chk(line_asserted, cv[2] & cv[3], "host sees interrupt");
			chk(line, cv[0] ^ (cv[2] & cv[3]), "line level");
		end
		wr_reg(`PPG_OFS_PIN_CFG, 16'h0000);
		set_bytes(8'h00);
		$display("t_pin done");
	endtask

	task automatic t_ratio();
		@(posedge i_clk);
		#1;
		measure_on = 1'b1;
		repeat (10 * SLOW_HALF) @(posedge i_clk);
		rd_chk(`PPG_OFS_CLK_RATIO, 16'(4 * SLOW_HALF), "ratio two slow periods");
		@(posedge i_clk);
		#1;
		measure_on = 1'b0;
		repeat (10 * SLOW_HALF) @(posedge i_clk);
		rd_chk(`PPG_OFS_CLK_RATIO, 16'(4 * SLOW_HALF), "ratio kept");
		$display("t_ratio done");
	endtask

	initial begin
		repeat (20) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		t_reset();
		t_modes();
		t_windows();
		t_fifo();
		t_pin();
		t_ratio();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		test_done();
	end
endmodule

`default_nettype wire
